// >>> core/blm_lead_monitor.sv
/*
 * Lead-condition monitor: serial register port, compliance monitor,
 * digital and DC lead-off, lead-on routing, bias and self-test load.
 * Assumes analog comparators and converter sit outside; pins are async.
 */
`timescale 1ns/1ps
`default_nettype none

`include "blm_map.svh"

// Behaviour
// - Compliance enable drives three drive-pin flags
// - Digital detector compares converter output to limits
// - Two 8-bit thresholds in dynamic register
// - Enable bits: 1x over, x1 under
// - DC lead-off field code 10 enables
// - DC current and window comparator flags
// - Lead-on flag alerts on enabled interrupt
// - Lead-bias enable, value, per-input connect fields
// - Zero-current 300 mV compliance selection offered
// - Self-test nominal and modulation load selection
// - Modulation rate from 62.5 mHz to 4 Hz
// - Code zero disables modulation
module blm_lead_monitor
    import blm_pkg::*;
#(
    parameter int ADC_W          = 20,
    parameter int MOD_HALF_TICKS = `BLM_MOD_HALF_TICKS
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             spi_csb_n,
    input  wire logic             spi_sclk,
    input  wire logic             spi_sdi,
    output var  logic             spi_sdo_out,
    output var  logic             spi_sdo_oe_n,
    input  wire logic             fclk_in,
    input  wire logic             adc_valid,
    input  wire logic [ADC_W-1:0] adc_code,
    input  wire logic             drive_out_pos_comp,
    input  wire logic             drive_out_neg_comp,
    input  wire logic             sense_in_pos_window,
    input  wire logic             sense_in_neg_window,
    input  wire logic             lead_on_comp,
    output var  logic             interrupt_out_1_n_out,
    output var  logic             interrupt_out_1_oe_n,
    output var  logic             interrupt_out_2_n_out,
    output var  logic             interrupt_out_2_oe_n,
    output var  logic             compliance_monitor_enable,
    output var  logic             dc_leadoff_active,
    output var  logic [2:0]       dc_current_code,
    output var  logic [1:0]       dc_threshold_code,
    output var  logic             dc_zero_300mv_sel,
    output var  logic             lead_on_detect_en,
    output var  logic [1:0]       lead_bias_enable,
    output var  logic [1:0]       lead_bias_value,
    output var  logic             lead_bias_pos_connect,
    output var  logic             lead_bias_neg_connect,
    output var  logic             load_enable,
    output var  logic [2:0]       load_nominal_code,
    output var  logic [3:0]       load_modulation_code,
    output var  logic             load_mod_step
);
    localparam int CW = $clog2(MOD_HALF_TICKS * 64) + 1;

    if (ADC_W < 8 || MOD_HALF_TICKS < 1 || MOD_HALF_TICKS > 4096) begin : g_chk
        $error("blm_lead_monitor: unsupported parameter values");
    end

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [8:0] pins_s;
    blm_sync #(.W(9)) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in ({~spi_csb_n, spi_sclk, spi_sdi, fclk_in,
                    drive_out_pos_comp, drive_out_neg_comp,
                    sense_in_pos_window, sense_in_neg_window,
                    lead_on_comp}),
        .sync_out (pins_s)
    );

    logic csb_s, sclk_s, sdi_s, fclk_s, dpos_s, dneg_s, wpos_s, wneg_s;
    logic lon_s, csb_on_s;
    // Select travels inverted so a flushed synchroniser reads deselected
    assign csb_s = ~csb_on_s;
    assign {csb_on_s, sclk_s, sdi_s, fclk_s, dpos_s, dneg_s,
            wpos_s, wneg_s, lon_s} = pins_s;

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    blm_word_t dyn_q, dyn_d, gen_q, gen_d, mux_q, mux_d;
    logic      cpmon_q, cpmon_d, ien1_q, ien1_d, ien2_q, ien2_d;
    logic      wr_stb;
    logic [6:0] wr_addr;
    blm_word_t  wr_data;

    always_comb begin
        dyn_d   = dyn_q;
        gen_d   = gen_q;
        mux_d   = mux_q;
        cpmon_d = cpmon_q;
        ien1_d  = ien1_q;
        ien2_d  = ien2_q;
        if (wr_stb) begin
            case (wr_addr)
                `BLM_ADDR_DYN_MGMT: dyn_d   = wr_data;
                `BLM_ADDR_GEN_CFG:  gen_d   = wr_data;
                `BLM_ADDR_MUX_CFG:  mux_d   = wr_data;
                `BLM_ADDR_CHAN_CFG: cpmon_d = wr_data[`BLM_CC_CPMON];
                `BLM_ADDR_INT1_EN:  ien1_d  = wr_data[`BLM_ST_LEAD_ON];
                `BLM_ADDR_INT2_EN:  ien2_d  = wr_data[`BLM_ST_LEAD_ON];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dyn_q   <= `BLM_RST_WORD;
            gen_q   <= `BLM_RST_WORD;
            mux_q   <= `BLM_RST_WORD;
            cpmon_q <= 1'b0;
            ien1_q  <= 1'b0;
            ien2_q  <= 1'b0;
        end else begin
            dyn_q   <= dyn_d;
            gen_q   <= gen_d;
            mux_q   <= mux_d;
            cpmon_q <= cpmon_d;
            ien1_q  <= ien1_d;
            ien2_q  <= ien2_d;
        end
    end

    logic [7:0] thr_hi, thr_lo;
    logic [1:0] dig_en;
    assign thr_hi = dyn_q[`BLM_DM_HI_THR +: 8];
    assign thr_lo = dyn_q[`BLM_DM_LO_THR +: 8];
    assign dig_en = gen_q[`BLM_GC_DIG_LOFF +: 2];

    assign compliance_monitor_enable = cpmon_q;
    assign dc_leadoff_active = gen_q[`BLM_GC_DC_LOFF +: 2]
                               == `BLM_DC_LOFF_ON;
    assign dc_current_code   = gen_q[`BLM_GC_DC_CUR +: 3];
    assign dc_threshold_code = gen_q[`BLM_GC_DC_THR +: 2];
    assign dc_zero_300mv_sel = dc_current_code == 3'h0;
    assign lead_on_detect_en = gen_q[`BLM_GC_LON_EN];
    assign lead_bias_enable  = gen_q[`BLM_GC_BIAS_EN +: 2];
    assign lead_bias_value   = gen_q[`BLM_GC_BIAS_VAL +: 2];
    assign lead_bias_pos_connect = gen_q[`BLM_GC_BIAS_POS];
    assign lead_bias_neg_connect = gen_q[`BLM_GC_BIAS_NEG];
    assign load_enable          = mux_q[`BLM_MX_LOAD_EN];
    assign load_nominal_code    = mux_q[`BLM_MX_NOM +: 3];
    assign load_modulation_code = mux_q[`BLM_MX_MOD +: 4];

    // -----------------------------------------------------------------
    // Detection flags
    // -----------------------------------------------------------------
    logic [7:0] flag_q, flag_d;
    logic       int1_q, int1_d, int2_q, int2_d;
    logic [7:0] top;
    logic [8:0] mag;
    logic       over_c, under_c;

    always_comb begin
        top     = adc_code[ADC_W-1 -: 8];
        mag     = top[7] ? 9'h000 - {top[7], top} : {1'b0, top};
        over_c  = mag > {1'b0, thr_hi};
        under_c = mag < {1'b0, thr_lo};
        flag_d  = flag_q;
        if (adc_valid) begin
            flag_d[`BLM_ST_OVER]  = dig_en[1] & over_c;
            flag_d[`BLM_ST_UNDER] = dig_en[0] & under_c;
            flag_d[`BLM_ST_DRV_POS_OOC] = cpmon_q & dpos_s;
            flag_d[`BLM_ST_DRV_NEG_OOC] = cpmon_q & dneg_s;
            flag_d[`BLM_ST_DRV_OOC] = cpmon_q & (dpos_s | dneg_s);
            flag_d[`BLM_ST_DC_POS] = dc_leadoff_active & wpos_s;
            flag_d[`BLM_ST_DC_NEG] = dc_leadoff_active & wneg_s;
        end
        // Lead-on runs in standby, without converter samples
        flag_d[`BLM_ST_LEAD_ON] = lead_on_detect_en & lon_s;
        int1_d = ien1_q & flag_d[`BLM_ST_LEAD_ON];
        int2_d = ien2_q & flag_d[`BLM_ST_LEAD_ON];
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_q <= 8'h00;
            int1_q <= 1'b0;
            int2_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            int1_q <= int1_d;
            int2_q <= int2_d;
        end
    end

    // Active-low, released when the source is not routed there
    assign interrupt_out_1_n_out = ~int1_q;
    assign interrupt_out_1_oe_n  = ~ien1_q;
    assign interrupt_out_2_n_out = ~int2_q;
    assign interrupt_out_2_oe_n  = ~ien2_q;

    // -----------------------------------------------------------------
    // Self-test load modulation
    // -----------------------------------------------------------------
    logic          fclk_prev_q, fclk_prev_d, phase_q, phase_d;
    logic [CW-1:0] mcnt_q, mcnt_d, half;
    logic [2:0]    rate;
    logic          mod_on;

    always_comb begin
        rate = mux_q[`BLM_MX_RATE +: 3];
        if (rate > 3'(`BLM_MOD_RATE_STEPS)) begin
            rate = 3'(`BLM_MOD_RATE_STEPS);
        end
        half   = CW'(MOD_HALF_TICKS) << rate;
        mod_on = load_enable & (load_modulation_code != 4'h0);
        fclk_prev_d = fclk_s;
        mcnt_d  = mcnt_q;
        phase_d = phase_q;
        if (!mod_on) begin
            mcnt_d  = '0;
            phase_d = 1'b0;
        end else if (fclk_s & ~fclk_prev_q) begin
            if (mcnt_q >= half - CW'(1)) begin
                mcnt_d  = '0;
                phase_d = ~phase_q;
            end else begin
                mcnt_d = mcnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fclk_prev_q <= 1'b0;
            mcnt_q      <= '0;
            phase_q     <= 1'b0;
        end else begin
            fclk_prev_q <= fclk_prev_d;
            mcnt_q      <= mcnt_d;
            phase_q     <= phase_d;
        end
    end

    assign load_mod_step = phase_q;

    // -----------------------------------------------------------------
    // Serial register port
    // -----------------------------------------------------------------
    blm_spi_state_t st_q, st_d;
    logic       sclk_prev_q, sclk_prev_d;
    logic [7:0] cmd_q, cmd_d;
    logic [4:0] cnt_q, cnt_d;
    blm_word_t  sh_q, sh_d, rd_data;
    logic       rise, fall;

    always_comb begin
        case (cmd_q[7:1])
            `BLM_ADDR_STATUS:   rd_data = {16'h0000, flag_q};
            `BLM_ADDR_INT1_EN:  rd_data = 24'(ien1_q) << `BLM_ST_LEAD_ON;
            `BLM_ADDR_INT2_EN:  rd_data = 24'(ien2_q) << `BLM_ST_LEAD_ON;
            `BLM_ADDR_DYN_MGMT: rd_data = dyn_q;
            `BLM_ADDR_GEN_CFG:  rd_data = gen_q;
            `BLM_ADDR_MUX_CFG:  rd_data = mux_q;
            `BLM_ADDR_CHAN_CFG: rd_data = 24'(cpmon_q) << `BLM_CC_CPMON;
            default:            rd_data = 24'h000000;
        endcase
        rise = sclk_s & ~sclk_prev_q;
        fall = ~sclk_s & sclk_prev_q;
        sclk_prev_d = sclk_s;
        st_d    = st_q;
        cmd_d   = cmd_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        wr_stb  = 1'b0;
        wr_addr = cmd_q[7:1];
        wr_data = {sh_q[22:0], sdi_s};
        if (csb_s) begin
            st_d = SPI_IDLE;
        end else begin
            case (st_q)
                SPI_IDLE: begin
                    st_d  = SPI_CMD;
                    cnt_d = 5'h00;
                end
                SPI_CMD: if (rise) begin
                    cmd_d = {cmd_q[6:0], sdi_s};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        st_d  = SPI_DATA;
                        cnt_d = 5'h00;
                    end
                end
                SPI_DATA: begin
                    if (cnt_q == 5'h00 && !fall && !rise) begin
                        sh_d = cmd_q[0] ? rd_data : 24'h000000;
                    end
                    if (fall && cnt_q != 5'h00 && cmd_q[0]) begin
                        sh_d = {sh_q[22:0], 1'b0};
                    end
                    if (rise) begin
                        cnt_d = cnt_q + 5'h01;
                        if (!cmd_q[0]) begin
                            sh_d = {sh_q[22:0], sdi_s};
                        end
                        if (cnt_q == 5'h17) begin
                            st_d   = SPI_DONE;
                            wr_stb = ~cmd_q[0];
                        end
                    end
                end
                SPI_DONE: ;
                default: st_d = SPI_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q        <= SPI_IDLE;
            sclk_prev_q <= 1'b0;
            cmd_q       <= 8'h00;
            cnt_q       <= 5'h00;
            sh_q        <= 24'h000000;
            spi_sdo_oe_n <= 1'b1;
        end else begin
            st_q        <= st_d;
            sclk_prev_q <= sclk_prev_d;
            cmd_q       <= cmd_d;
            cnt_q       <= cnt_d;
            sh_q        <= sh_d;
            spi_sdo_oe_n <= csb_s;
        end
    end

    assign spi_sdo_out = sh_q[23] & cmd_q[0] & (st_q == SPI_DATA);

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_cgm_flags: assert property (adc_valid && cpmon_q && dpos_s
        |=> flag_q[`BLM_ST_DRV_POS_OOC] && flag_q[`BLM_ST_DRV_OOC])
        else $error("positive drive compliance flag missing");
    a_cgm_idle: assert property (adc_valid && !cpmon_q
        |=> flag_q[4:2] == 3'b000)
        else $error("compliance flags set while monitor off");
    a_over_hit: assert property (adc_valid && dig_en[1]
        && over_c |=> flag_q[`BLM_ST_OVER])
        else $error("over-threshold flag missing");
    a_under_gate: assert property (adc_valid && !dig_en[0]
        |=> !flag_q[`BLM_ST_UNDER])
        else $error("under flag set while check disabled");
    a_thr_low: assert property (adc_valid && mag < {1'b0, thr_lo}
        && dig_en == 2'b11 |=> flag_q[`BLM_ST_UNDER])
        else $error("low threshold not applied");
    a_dc_window: assert property (adc_valid && !dc_leadoff_active
        |=> flag_q[6:5] == 2'b00)
        else $error("DC lead-off flag while not enabled");
    a_lon_alert: assert property (lead_on_detect_en && lon_s
        && ien1_q && !(wr_stb && wr_addr == `BLM_ADDR_INT1_EN)
        |=> !interrupt_out_1_n_out && !interrupt_out_1_oe_n)
        else $error("lead-on not signalled on first output");
    a_mod_off: assert property (!mod_on |=> !load_mod_step)
        else $error("modulation active with zero code");
    a_stat_hold: assert property (!adc_valid |=>
        flag_q[6:0] == $past(flag_q[6:0]))
        else $error("flags changed without a sample");

    c_write: cover property (wr_stb);
    c_over: cover property (flag_q[`BLM_ST_OVER]);
    c_lead_on_int: cover property (!interrupt_out_2_n_out);
    c_mod_toggle: cover property ($rose(load_mod_step));
endmodule : blm_lead_monitor

`default_nettype wire

// >>> inc/blm_map.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * lead-condition monitor.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BLM_MAP_SVH
`define BLM_MAP_SVH

// ---------------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------------
`define BLM_ADDR_STATUS      7'h01
`define BLM_ADDR_INT1_EN     7'h02
`define BLM_ADDR_INT2_EN     7'h03
`define BLM_ADDR_DYN_MGMT    7'h05
`define BLM_ADDR_GEN_CFG     7'h10
`define BLM_ADDR_MUX_CFG     7'h17
`define BLM_ADDR_CHAN_CFG    7'h18

// ---------------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------------
`define BLM_ST_OVER          0
`define BLM_ST_UNDER         1
`define BLM_ST_DRV_OOC       2
`define BLM_ST_DRV_POS_OOC   3
`define BLM_ST_DRV_NEG_OOC   4
`define BLM_ST_DC_POS        5
`define BLM_ST_DC_NEG        6
`define BLM_ST_LEAD_ON       7

// ---------------------------------------------------------------------
// Field positions (lsb)
// ---------------------------------------------------------------------
`define BLM_DM_HI_THR        8
`define BLM_DM_LO_THR        0
`define BLM_GC_LON_EN        22
`define BLM_GC_DIG_LOFF      20
`define BLM_GC_DC_LOFF       12
`define BLM_GC_DC_CUR        9
`define BLM_GC_DC_THR        6
`define BLM_GC_BIAS_EN       4
`define BLM_GC_BIAS_VAL      2
`define BLM_GC_BIAS_POS      1
`define BLM_GC_BIAS_NEG      0
`define BLM_MX_NOM           13
`define BLM_MX_MOD           8
`define BLM_MX_RATE          4
`define BLM_MX_LOAD_EN       3
`define BLM_CC_CPMON         5

// ---------------------------------------------------------------------
// Reset value and DC lead-off enable code
// ---------------------------------------------------------------------
`define BLM_RST_WORD         24'h000000
`define BLM_DC_LOFF_ON       2'h2

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define BLM_FCLK_HZ          32768
`define BLM_MOD_MAX_MHZ      4000
`define BLM_MOD_RATE_STEPS   6
`define BLM_MOD_HALF_TICKS   (`BLM_FCLK_HZ * 1000 / (2 * `BLM_MOD_MAX_MHZ))

`endif

// >>> inc/blm_pkg.sv
/*
 * Types shared by the lead-condition monitor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package blm_pkg;
    typedef logic [23:0] blm_word_t;
    typedef enum {SPI_IDLE, SPI_CMD, SPI_DATA, SPI_DONE} blm_spi_state_t;
endpackage : blm_pkg

`default_nettype wire

// >>> core/blm_sync.sv
/*
 * Two-stage synchroniser for a bus of unrelated levels.
 * Assumes each bit is an independent level from outside mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module blm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : blm_sync

`default_nettype wire

// >>> tb/blm_host_model.sv
/*
 * Serial host model that reaches the monitor's registers.
 * Assumes calls begin just after an mclk edge, with reset released.
 */
`timescale 1ns/1ps
`default_nettype none

module blm_host_model
    import blm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic spi_sdo_out,
    input  wire logic spi_sdo_oe_n,
    output var  logic spi_csb_n,
    output var  logic spi_sclk,
    output var  logic spi_sdi
);
    logic sdo_last;
    logic sdo_w;

    // Released line shows the inverse of the last driven bit
    always @(posedge mclk) begin
        if (!spi_sdo_oe_n) sdo_last <= spi_sdo_out;
    end
    assign sdo_w = spi_sdo_oe_n ? ~sdo_last : spi_sdo_out;

    initial begin
        spi_csb_n = 1'b1;
        spi_sclk  = 1'b0;
        spi_sdi   = 1'b0;
        sdo_last  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // -----------------------------------------------------------------
    // One frame: address, read flag, then 24 data bits, MSB first
    // -----------------------------------------------------------------
    task automatic xfer(input logic [6:0] a, input logic rd,
                        input blm_word_t wd, output blm_word_t rdat);
        logic [31:0] w;
        w = {a, rd, wd};
        rdat = 24'h000000;
        spi_csb_n = 1'b0;
        tick(6);
        for (int i = 31; i >= 0; i--) begin
            spi_sdi = w[i];
            tick(6);
            if (i < 24) rdat[i] = sdo_w;
            spi_sclk = 1'b1;
            tick(6);
            spi_sclk = 1'b0;
        end
        tick(6);
        spi_csb_n = 1'b1;
        tick(8);
    endtask : xfer
endmodule : blm_host_model

`default_nettype wire

// >>> tb/blm_lead_monitor_tb_top.sv
/*
 * Self-checking bench of the lead-condition monitor.
 * Assumes blm_host_model as serial host; comparator pins driven here.
 */
`timescale 1ns/1ps
`default_nettype none

module blm_lead_monitor_tb_top
    import blm_pkg::*;
;
    logic        mclk = 1'b0, sys_rst = 1'b1, fclk_in = 1'b0;
    logic        adc_valid = 1'b0, dp = 1'b0, dn = 1'b0;
    logic        sp = 1'b0, sn = 1'b0, lon = 1'b0;
    logic [19:0] adc_code = 20'h00000;
    logic        csb, sck, sdi, sdo, sdo_oe_n, i1_n, i1_oe_n, i2_n;
    logic        i2_oe_n, cgm, dca, dcz, lod, bp, bn, le, mstep;
    logic [2:0]  dcc, nom;
    logic [1:0]  dct, be, bv;
    logic [3:0]  mcode;
    blm_word_t   rdat, ov;
    int          err_total = 0, cmp_count = 0, n;

    localparam logic [6:0] RA [6] = '{7'h05, 7'h10, 7'h17, 7'h18,
                                      7'h01, 7'h7F};
    localparam blm_word_t  RW [6] = '{24'h00C33C, 24'hFFFFFF,
        24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF};
    localparam blm_word_t  RE [6] = '{24'h00C33C, 24'hFFFFFF,
        24'hFFFFFF, 24'h000020, 24'h000000, 24'h000000};
    localparam blm_word_t  RO [6] = '{24'h000200, 24'h3FFC00,
        24'h3FFDFE, 24'h3FFDFF, 24'h3FFDFF, 24'h3FFDFF};

    always #2.5 mclk = ~mclk;
    always #100 fclk_in = ~fclk_in;
    assign ov = 24'({lod, be, bv, bp, bn, dcc, dct, dcz, le, nom, mcode,
                     cgm});

    blm_host_model host (.mclk(mclk), .spi_sdo_out(sdo),
        .spi_sdo_oe_n(sdo_oe_n), .spi_csb_n(csb), .spi_sclk(sck),
        .spi_sdi(sdi));
    blm_lead_monitor #(.MOD_HALF_TICKS(2)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .spi_csb_n(csb), .spi_sclk(sck),
        .spi_sdi(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n(sdo_oe_n),
        .fclk_in(fclk_in), .adc_valid(adc_valid), .adc_code(adc_code),
        .drive_out_pos_comp(dp), .drive_out_neg_comp(dn),
        .sense_in_pos_window(sp), .sense_in_neg_window(sn),
        .lead_on_comp(lon), .interrupt_out_1_n_out(i1_n),
        .interrupt_out_1_oe_n(i1_oe_n), .interrupt_out_2_n_out(i2_n),
        .interrupt_out_2_oe_n(i2_oe_n), .compliance_monitor_enable(cgm),
        .dc_leadoff_active(dca), .dc_current_code(dcc),
        .dc_threshold_code(dct), .dc_zero_300mv_sel(dcz),
        .lead_on_detect_en(lod), .lead_bias_enable(be),
        .lead_bias_value(bv), .lead_bias_pos_connect(bp),
        .lead_bias_neg_connect(bn), .load_enable(le),
        .load_nominal_code(nom), .load_modulation_code(mcode),
        .load_mod_step(mstep));

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input blm_word_t s, input blm_word_t e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input blm_word_t d);
        host.xfer(a, 1'b0, d, rdat);
    endtask : wr

    task automatic rd(input logic [6:0] a, input blm_word_t e);
        host.xfer(a, 1'b1, 24'h000000, rdat);
        chk(rdat, e);
    endtask : rd

    task automatic samp(input logic [19:0] c);
        adc_code = c;
        repeat (6) @(posedge mclk);
        #1 adc_valid = 1'b1;
        @(posedge mclk);
        #1 adc_valid = 1'b0;
    endtask : samp

    task automatic tog(output int t);
        logic p;
        t = 0;
        p = mstep;
        repeat (800) begin
            @(posedge mclk);
            #1;
            if (mstep !== p) t++;
            p = mstep;
        end
    endtask : tog

    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        give_verdict();
    end

    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        #1 chk(24'({i1_n, i1_oe_n, i2_n, i2_oe_n, sdo_oe_n, dcz, mstep,
                   cgm}), 24'h0000FC);
        sys_rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        for (int i = 0; i < 6; i++) begin
            rd(RA[i], 24'h000000);
            wr(RA[i], RW[i]);
            rd(RA[i], RE[i]);
            chk(ov, RO[i]);
        end
        wr(7'h05, 24'h004010);
        for (int c = 0; c < 4; c++) begin
            wr(7'h10, 24'(c) << 20);
            samp(20'h50000);
            rd(7'h01, 24'(c[1]));
            samp(20'h08000);
            rd(7'h01, 24'(c[0]) << 1);
        end
        samp(20'h40000);
        rd(7'h01, 24'h000000);
        wr(7'h10, 24'h000000);
        for (int k = 0; k < 4; k++) begin
            wr(7'h18, 24'(k[1]) << 5);
            dp = k[0];
            dn = ~k[0];
            samp(20'h00000);
            rd(7'h01, k<2 ? 24'h00 : k[0] ? 24'h0C : 24'h14);
        end
        dp = 1'b0;
        dn = 1'b0;
        sp = 1'b1;
        sn = 1'b1;
        for (int f = 0; f < 4; f++) begin
            wr(7'h10, 24'(f) << 12);
            chk(24'({dca, dcz}), f == 2 ? 24'h3 : 24'h1);
            samp(20'h00000);
            rd(7'h01, f == 2 ? 24'h60 : 24'h00);
        end
        sp = 1'b0;
        sn = 1'b0;
        lon = 1'b1;
        wr(7'h10, 24'h400000);
        chk(24'({be, bp, bn}), 24'h0);
        wr(7'h02, 24'h000080);
        rd(7'h01, 24'h000080);
        chk(24'({i1_n, i1_oe_n, i2_oe_n}), 24'h1);
        wr(7'h02, 24'h000000);
        wr(7'h03, 24'h000080);
        chk(24'({i1_oe_n, i2_n, i2_oe_n}), 24'h4);
        lon = 1'b0;
        repeat (8) @(posedge mclk);
        #1 chk(24'(i2_n), 24'h1);
        wr(7'h17, 24'h000008);
        tog(n);
        chk(24'(n), 24'h0);
        wr(7'h17, 24'h000108);
        tog(n);
        chk(24'(n >= 9 && n <= 11), 24'h1);
        wr(7'h17, 24'h000118);
        tog(n);
        chk(24'(n >= 4 && n <= 6), 24'h1);
        sys_rst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1 rd(7'h17, 24'h000000);
        give_verdict();
    end
endmodule : blm_lead_monitor_tb_top

`default_nettype wire
